// ===== hdl/pwit_consts.vh
// Constants for the pulse width / interval timer
//
// Notes on behaviour
// - Interval start loads buffer minus one, counts down
// - Counting starts on next count clock tick
// - Reload mode wrap reloads buffer minus one
// - Buffer writes apply only at next reload
// - Toggle at one-to-zero, wrap flag one tick after the wrap
// - Buffer one gives one-tick toggle per interval
// - One-shot wrap toggles output and clears run
// - Wrap flag sets regardless of irq gate
// - Stopped timer holds toggle output value
// - Wrap flag with gate raises interrupt
// - Software stop at wrap suppresses wrap flag
// - Enabling gate with pending flag interrupts at once
// - Measure: all-ones on start edge, count down
// - End edge captures count, sets done, held
// - Measurement re-arms itself after capture
// - Held buffer keeps old value, drops new
// - Reading buffer clears held flag
// - Measure wrap sets wrap flag, keeps counting
// - Stop at end edge suppresses done, held
// - Pattern 000 measures high width
// - Function select: zero interval, one measure
// - One-shot select: zero reload, one one-shot
// - Interrupt is gate AND any flag
`ifndef PWIT_CONSTS_VH
`define PWIT_CONSTS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PWIT_OFF_RUN 8'h00
`define PWIT_OFF_FUNC 8'h04
`define PWIT_OFF_BUF 8'h08
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PWIT_B_EN 7
`define PWIT_B_DRV 6
`define PWIT_B_IE 5
`define PWIT_B_UF 2
`define PWIT_B_IR 1
`define PWIT_B_BF 0
`define PWIT_B_FC 7
`define PWIT_B_RM 6
`define PWIT_B_T0 5
`define PWIT_TSEL_HI 4
`define PWIT_TSEL_LO 3
`define PWIT_PAT_HI 2
`define PWIT_PAT_LO 0
// ----------------------------------------
// Values
// ----------------------------------------
`define PWIT_RST_BYTE 8'h00
`define PWIT_ALL_ONES 8'hFF
`define PWIT_ONE 8'h01
`define PWIT_ZERO 8'h00
`define PWIT_PAT_HIGH 3'h0
`define PWIT_TSEL_EXT 2'h3
`define PWIT_RESP_OK 2'h0
`define PWIT_RESP_ERR 2'h2
`endif

// ===== hdl/pulse_width_interval_timer.v
// Pulse width measurer and interval timer with AXI4-Lite registers
//
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "pwit_consts.vh"

module pulse_width_interval_timer #(
  parameter ADDR_W = 8,
  parameter [7:0] DIV0_MASK = 8'h01,
  parameter [7:0] DIV1_MASK = 8'h07,
  parameter [7:0] DIV2_MASK = 8'h1F
) (
  input wire aclk,
  input wire aresetn,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire measured_input_pin,
  input wire ext_tick_pin,
  output wire toggle_out_pin,
  output wire toggle_out_oe,
  output wire timer_irq_line
);

  // ----------------------------------------
  // Bus slave state
  // ----------------------------------------
  reg awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  reg aw_hold_q, w_hold_q;
  reg [ADDR_W-1:0] awaddr_q;
  reg [7:0] wdata_q;
  reg wstrb_q;
  reg [1:0] bresp_q, rresp_q;
  reg [31:0] rdata_q;

  // ----------------------------------------
  // Timer state
  // ----------------------------------------
  reg en_q, drv_q, ie_q, uf_q, ir_q, bf_q;
  reg fc_q, rm_q, t0_q;
  reg [1:0] tsel_q;
  reg [2:0] pat_q;
  reg [7:0] buf_q, cnt_q, presc_q;
  reg counting_q, uf_pend_q;
  reg in_s1_q, in_s2_q, in_p_q;
  reg ext_s1_q, ext_s2_q, ext_p_q;
  reg pin_q, oe_q, irq_q;

  // ----------------------------------------
  // Decode of accesses
  // ----------------------------------------
  wire aw_take = s_axi_awvalid & awready_q;
  wire w_take = s_axi_wvalid & wready_q;
  wire ar_take = s_axi_arvalid & arready_q;
  wire do_wr = aw_hold_q & w_hold_q & ~bvalid_q;
  wire wa_run = (awaddr_q == `PWIT_OFF_RUN);
  wire wa_func = (awaddr_q == `PWIT_OFF_FUNC);
  wire wa_buf = (awaddr_q == `PWIT_OFF_BUF);
  wire wr_run = do_wr & wstrb_q & wa_run;
  wire wr_func = do_wr & wstrb_q & wa_func;
  wire wr_buf = do_wr & wstrb_q & wa_buf;
  wire ra_run = (s_axi_araddr == `PWIT_OFF_RUN);
  wire ra_func = (s_axi_araddr == `PWIT_OFF_FUNC);
  wire ra_buf = (s_axi_araddr == `PWIT_OFF_BUF);
  wire rd_buf = ar_take & ra_buf;

  // ----------------------------------------
  // Count clock selection
  // ----------------------------------------
  // Edges of the synchronised pins, stage two onward only
  wire in_rise = in_s2_q & ~in_p_q;
  wire in_fall = ~in_s2_q & in_p_q;
  wire ext_rise = ext_s2_q & ~ext_p_q;
  reg tick;
  always @* begin
    case (tsel_q)
      2'h0: tick = ((presc_q & DIV0_MASK) == DIV0_MASK);
      2'h1: tick = ((presc_q & DIV1_MASK) == DIV1_MASK);
      2'h2: tick = ((presc_q & DIV2_MASK) == DIV2_MASK);
      `PWIT_TSEL_EXT: tick = ext_rise;
      default: tick = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Timer events
  // ----------------------------------------
  wire sw_start = wr_run & wdata_q[`PWIT_B_EN] & ~en_q;
  wire sw_stop = wr_run & ~wdata_q[`PWIT_B_EN] & en_q;
  wire step = en_q & counting_q & tick;
  wire at_zero = (cnt_q == `PWIT_ZERO);
  wire wrap = step & at_zero;
  // High width only: start on rise, end on fall
  wire m_start = en_q & fc_q & ~counting_q & in_rise;
  wire m_end = en_q & fc_q & counting_q & in_fall;
  // Reload mode toggles as the count reaches zero
  wire to_zero = (cnt_q == `PWIT_ONE) | (at_zero & (buf_q == `PWIT_ONE));
  wire t0_flip = ~fc_q & step & (rm_q ? at_zero : to_zero);
  wire uf_set = (fc_q & wrap & ~sw_stop) | (uf_pend_q & tick);
  wire ir_set = m_end & ~sw_stop;
  wire bf_set = ir_set & ~bf_q;
  wire uf_clr = wr_run & ~wdata_q[`PWIT_B_UF];
  wire ir_clr = wr_run & ~wdata_q[`PWIT_B_IR];
  wire [7:0] reload = buf_q - `PWIT_ONE;

  // ----------------------------------------
  // Write channel handshake
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= {ADDR_W{1'b0}};
      wdata_q <= `PWIT_RST_BYTE;
      wstrb_q <= 1'b0;
      bresp_q <= `PWIT_RESP_OK;
    end else begin
      if (aw_take) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        awready_q <= 1'b0;
      end
      if (w_take) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata[7:0];
        wstrb_q <= s_axi_wstrb[0];
        wready_q <= 1'b0;
      end
      if (do_wr) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (wa_run | wa_func | wa_buf) ? `PWIT_RESP_OK : `PWIT_RESP_ERR;
      end else if (bvalid_q & s_axi_bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `PWIT_RESP_OK;
    end else if (ar_take) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= (ra_run | ra_func | ra_buf) ? `PWIT_RESP_OK : `PWIT_RESP_ERR;
      if (ra_run)
        rdata_q <= {24'h00_0000, en_q, drv_q, ie_q, 2'b00, uf_q, ir_q, bf_q};
      else if (ra_func)
        rdata_q <= {24'h00_0000, fc_q, rm_q, t0_q, tsel_q, pat_q};
      else if (ra_buf)
        rdata_q <= {24'h00_0000, buf_q};
      else
        rdata_q <= 32'h0000_0000;
    end else if (rvalid_q & s_axi_rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // Synchronisers and prescaler
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      in_s1_q <= 1'b0;
      in_s2_q <= 1'b0;
      in_p_q <= 1'b0;
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_p_q <= 1'b0;
      presc_q <= `PWIT_ZERO;
    end else begin
      in_s1_q <= measured_input_pin;
      in_s2_q <= in_s1_q;
      in_p_q <= in_s2_q;
      ext_s1_q <= ext_tick_pin;
      ext_s2_q <= ext_s1_q;
      ext_p_q <= ext_s2_q;
      presc_q <= presc_q + `PWIT_ONE;
    end
  end

  // ----------------------------------------
  // Control fields and flags
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      drv_q <= 1'b0;
      ie_q <= 1'b0;
      uf_q <= 1'b0;
      ir_q <= 1'b0;
      bf_q <= 1'b0;
      uf_pend_q <= 1'b0;
      fc_q <= 1'b0;
      rm_q <= 1'b0;
      t0_q <= 1'b0;
      tsel_q <= 2'h0;
      pat_q <= `PWIT_PAT_HIGH;
      buf_q <= `PWIT_RST_BYTE;
    end else begin
      if (wr_run) begin
        drv_q <= wdata_q[`PWIT_B_DRV];
        ie_q <= wdata_q[`PWIT_B_IE];
      end
      // Interval wrap flag follows one tick after the wrap
      if (~fc_q & wrap & ~sw_stop)
        uf_pend_q <= 1'b1;
      else if (tick)
        uf_pend_q <= 1'b0;
      // Hardware set wins over a software clear
      uf_q <= uf_set | (uf_q & ~uf_clr);
      ir_q <= ir_set | (ir_q & ~ir_clr);
      bf_q <= bf_set | (bf_q & ~rd_buf);
      if (wr_func) begin
        fc_q <= wdata_q[`PWIT_B_FC];
        rm_q <= wdata_q[`PWIT_B_RM];
        tsel_q <= wdata_q[`PWIT_TSEL_HI:`PWIT_TSEL_LO];
        pat_q <= wdata_q[`PWIT_PAT_HI:`PWIT_PAT_LO];
      end
      // Toggle changes only on reload-mode steps to zero, one-shot wraps or a write
      if (t0_flip)
        t0_q <= ~t0_q;
      else if (wr_func)
        t0_q <= wdata_q[`PWIT_B_T0];
      // Buffer holds reload value or first unread capture
      if (bf_set)
        buf_q <= cnt_q;
      else if (wr_buf & ~fc_q)
        buf_q <= wdata_q;
    end
  end

  // ----------------------------------------
  // Down counter and run bit
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      en_q <= 1'b0;
      counting_q <= 1'b0;
      cnt_q <= `PWIT_ALL_ONES;
    end else if (sw_start) begin
      en_q <= 1'b1;
      counting_q <= ~fc_q;
      cnt_q <= fc_q ? `PWIT_ALL_ONES : reload;
    end else if (sw_stop) begin
      en_q <= 1'b0;
      counting_q <= 1'b0;
    end else if (fc_q) begin
      if (m_start) begin
        counting_q <= 1'b1;
        cnt_q <= `PWIT_ALL_ONES;
      end else if (m_end) begin
        counting_q <= 1'b0;
      end else if (step) begin
        cnt_q <= cnt_q - `PWIT_ONE;
      end
    end else if (wrap) begin
      if (rm_q) begin
        en_q <= 1'b0;
        counting_q <= 1'b0;
        cnt_q <= `PWIT_ALL_ONES;
      end else begin
        cnt_q <= reload;
      end
    end else if (step) begin
      cnt_q <= cnt_q - `PWIT_ONE;
    end
  end

  // ----------------------------------------
  // Registered pin and interrupt outputs
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_q <= 1'b0;
      oe_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      pin_q <= t0_q;
      oe_q <= drv_q;
      irq_q <= ie_q & (uf_q | ir_q | bf_q);
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign toggle_out_pin = pin_q;
  assign toggle_out_oe = oe_q;
  assign timer_irq_line = irq_q;

endmodule // pulse_width_interval_timer

// ===== verif/timer_props.sv
// Bus handshake and interrupt line checks for the timer block
`timescale 1ns/1ps
module timer_props (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire timer_irq_line
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Answers stand until taken
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data moved");
  // Answer latency, zero upper read data and release
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_awready ##1 s_axi_bvalid) else $error("write answer late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000) else $error("upper data set");
  a_write_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write not released");
  a_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read not released");
  // Request only falls after software acts
  a_irq_cause: assert property ($fell(timer_irq_line) |-> $past(s_axi_bvalid) || $past(s_axi_rvalid))
    else $error("irq fell on its own");
endmodule // timer_props
bind pulse_width_interval_timer timer_props u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .timer_irq_line);

// ===== verif/far_side_model.sv
// Pulse source and free running external tick
`timescale 1ns/1ps
module far_side_model (
  input wire aclk,
  input wire [15:0] pulse_len,
  input wire pulse_go,
  output logic pulse_pin,
  output logic tick_pin
);
  logic [15:0] cnt_q = 16'h0000;
  // High pulse of the requested length
  always @(posedge aclk) begin
    if (pulse_go) cnt_q <= pulse_len;
    else if (cnt_q != 16'h0000) cnt_q <= cnt_q - 16'h0001;
  end
  assign pulse_pin = (cnt_q != 16'h0000);
  // External count clock
  initial tick_pin = 1'h0;
  always @(posedge aclk) tick_pin <= ~tick_pin;
endmodule // far_side_model

// ===== verif/test_pulse_width_interval_timer.sv
// Self-checking bench for the pulse width and interval timer
`timescale 1ns/1ps
`include "pwit_consts.vh"
module test_pulse_width_interval_timer;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire measured_input_pin, ext_tick_pin, toggle_out_pin, toggle_out_oe, timer_irq_line;
  logic [15:0] pulse_len = 16'h0000;
  logic pulse_go = 1'h0;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [7:0] v;
  logic p;
  int n;

  always #4 aclk = ~aclk;

  pulse_width_interval_timer uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .measured_input_pin,
    .ext_tick_pin, .toggle_out_pin, .toggle_out_oe, .timer_irq_line);
  far_side_model far (.aclk, .pulse_len, .pulse_go, .pulse_pin(measured_input_pin), .tick_pin(ext_tick_pin));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task summarize;
    if (num_errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task chk_in(input string nm, input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] g);
    comparisons++;
    if (((g >= lo) && (g <= hi)) !== 1'b1) begin
      num_errors++;
      $display("unexpected %s: expected %h to %h seen %h", nm, lo, hi, g);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    chk("bresp", {6'h00, er}, {6'h00, s_axi_bresp});
    s_axi_bready <= 1'h0;
  endtask

  task rd(input logic [7:0] a, output logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata[7:0];
    chk("rresp", {6'h00, er}, {6'h00, s_axi_rresp});
    s_axi_rready <= 1'h0;
  endtask

  // Cycles until the toggle pin next changes, capped at 100
  task flip(output int k);
    logic q;
    k = 0;
    q = toggle_out_pin;
    do begin
      @(posedge aclk);
      k++;
    end while (toggle_out_pin === q && k < 100);
  endtask

  task pulse(input int len);
    @(posedge aclk);
    pulse_len <= len[15:0];
    pulse_go <= 1'h1;
    @(posedge aclk);
    pulse_go <= 1'h0;
    repeat (len + 12) @(posedge aclk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_regs;
    for (int i = 0; i < 3; i++) begin
      rd(8'(i * 4), v, `PWIT_RESP_OK);
      chk("reset_value", 8'h00, v);
    end
    rd(8'h0C, v, `PWIT_RESP_ERR);
    wr(8'h0C, 8'hFF, `PWIT_RESP_ERR);
  endtask

  task t_reload;
    logic [7:0] bufs [3];
    bufs = '{8'h04, 8'h02, 8'h01};
    wr(`PWIT_OFF_BUF, 8'h04, `PWIT_RESP_OK);
    wr(`PWIT_OFF_FUNC, 8'h00, `PWIT_RESP_OK);
    wr(`PWIT_OFF_RUN, 8'hE0, `PWIT_RESP_OK);
    for (int i = 0; i < 3; i++) begin
      if (i > 0) wr(`PWIT_OFF_BUF, bufs[i], `PWIT_RESP_OK);
      flip(n);
      flip(n);
      flip(n);
      chk("toggle_period", bufs[i] << 1, n[7:0]);
    end
    chk("toggle_oe", 8'h01, {7'h00, toggle_out_oe});
    rd(`PWIT_OFF_RUN, v, `PWIT_RESP_OK);
    chk("status_running", 8'hE4, v);
    chk("irq_line", 8'h01, {7'h00, timer_irq_line});
    wr(`PWIT_OFF_RUN, 8'h44, `PWIT_RESP_OK);
    repeat (2) @(posedge aclk);
    p = toggle_out_pin;
    repeat (20) @(posedge aclk);
    chk("toggle_stopped", {7'h00, p}, {7'h00, toggle_out_pin});
    rd(`PWIT_OFF_RUN, v, `PWIT_RESP_OK);
    chk("status_gated", 8'h44, v);
    chk("irq_gated", 8'h00, {7'h00, timer_irq_line});
    wr(`PWIT_OFF_RUN, 8'h64, `PWIT_RESP_OK);
    @(posedge aclk);
    chk("irq_on_gate", 8'h01, {7'h00, timer_irq_line});
    wr(`PWIT_OFF_RUN, 8'h40, `PWIT_RESP_OK);
  endtask

  // One-shot on the external tick, which rises every second cycle
  task t_oneshot;
    wr(`PWIT_OFF_BUF, 8'h03, `PWIT_RESP_OK);
    wr(`PWIT_OFF_FUNC, 8'h58, `PWIT_RESP_OK);
    wr(`PWIT_OFF_RUN, 8'hC0, `PWIT_RESP_OK);
    flip(n);
    chk_in("one_shot_first", 8'h06, 8'h07, n[7:0]);
    flip(n);
    chk("one_shot_no_reflip", 8'h64, n[7:0]);
    rd(`PWIT_OFF_RUN, v, `PWIT_RESP_OK);
    chk("status_one_shot", 8'h44, v);
  endtask

  task t_measure;
    wr(`PWIT_OFF_FUNC, 8'h80, `PWIT_RESP_OK);
    wr(`PWIT_OFF_RUN, 8'hA0, `PWIT_RESP_OK);
    pulse(20);
    rd(`PWIT_OFF_RUN, v, `PWIT_RESP_OK);
    chk("status_captured", 8'hA3, v);
    pulse(40);
    rd(`PWIT_OFF_BUF, v, `PWIT_RESP_OK);
    chk_in("first_capture", 8'hF4, 8'hF6, v);
    rd(`PWIT_OFF_RUN, v, `PWIT_RESP_OK);
    chk("status_read", 8'hA2, v);
    pulse(40);
    rd(`PWIT_OFF_BUF, v, `PWIT_RESP_OK);
    chk_in("rearm_capture", 8'hEA, 8'hEC, v);
    pulse(560);
    rd(`PWIT_OFF_RUN, v, `PWIT_RESP_OK);
    chk("wrap_in_measure", 8'h04, v & 8'h04);
    wr(`PWIT_OFF_RUN, 8'h00, `PWIT_RESP_OK);
  endtask

  // ----------------------------------------
  // Sequence and hang guard
  // ----------------------------------------
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      summarize;
    end
  end

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs;
    t_reload;
    t_oneshot;
    t_measure;
    summarize;
  end
endmodule // test_pulse_width_interval_timer
